// File: cmc_params.svh
// Constants for the contact monitor control block
// What this block does
// - Three modes: normal, scan, shutdown; normal keeps sense resistors on all inputs except direct inputs 0-1.
// - Scan mode connects sense resistors only during a short polling window.
// - Shutdown places every switch input in high impedance.
// - Shutdown pin low enters shutdown; high runs normally.
// - One readable status bit per switch input, eight in all.
// - Per-input interrupt block bit stops that input raising the interrupt.
// - After reset all block bits are clear, every input except direct inputs 0-1 may interrupt.
// - Interrupt output asserts low when an enabled input changes state.
// - Inputs 0-3 ground sensing; inputs 4-7 pairwise selectable by two bits.
// - Reset default: inputs 2-7 ground sensing, inputs 0-1 direct pass-through.
// - Sense resistor pulls up on ground inputs, down on battery inputs.
// - Direct bit clear in normal mode drives inputs 0-1 onto pass-through outputs.
// - Direct bit clear disables sense resistors and wetting on inputs 0-1.
// - Direct inputs neither update status bits nor raise the interrupt.
// - One common debounce, hysteresis and wetting setting for all inputs.
// - Host sets masking, hysteresis, wetting, polarity, scan period over APB.
// - Status and interrupt update only after input stable for full debounce time.
// - Scan mode: change moves to a scan-debounce state with sense resistors on, then returns to scan.
// - Interrupt released when the host begins a register transfer.
// - Pass-through outputs high impedance when direct bit set or in scan mode.
`ifndef CMC_PARAMS_SVH
`define CMC_PARAMS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define CMC_ADDR_CMD     12'h000
`define CMC_ADDR_STATUS  12'h004
`define CMC_ADDR_SCAN    12'h008
// ----------------------------------------
// Command fields
// ----------------------------------------
`define CMC_CMD_BLOCK_LSB   0
`define CMC_CMD_PAIR_A      8
`define CMC_CMD_PAIR_B      9
`define CMC_CMD_DIRECT      10
`define CMC_CMD_SCAN_EN     11
`define CMC_CMD_HYST_EN     12
`define CMC_CMD_WET_EN      13
`define CMC_CMD_RESET       32'h0000_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define CMC_CLK_NS          40
`define CMC_DEB_US          5000
`define CMC_DEB_CYC         ((`CMC_DEB_US * 1000) / `CMC_CLK_NS)
`define CMC_POLL_NS         40000
`define CMC_POLL_CYC        ((`CMC_POLL_NS + `CMC_CLK_NS - 1) / `CMC_CLK_NS)
`define CMC_SCAN_RESET      16'h0100
`endif

// File: cmc_pkg.sv
// Types for the contact monitor control block
package cmc_pkg;
	typedef enum logic [1:0] {
		CMC_NORMAL   = 2'b00,
		CMC_SCAN     = 2'b01,
		CMC_SCAN_DEB = 2'b11,
		CMC_SHUTDOWN = 2'b10
	} cmc_mode_t;

	typedef struct packed {
		logic [31:0] cmd;
		logic [15:0] scan_period;
		logic [7:0]  state;
		logic [7:0]  pending;
		logic [31:0] deb_cnt;
		logic [15:0] scan_cnt;
		logic [15:0] poll_cnt;
		cmc_mode_t   mode;
		logic        irq_n;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
		logic [1:0]  pass_out;
		logic [1:0]  pass_oe;
		logic [7:0]  pull_up;
		logic [7:0]  pull_dn;
		logic [7:0]  wet_en;
		logic        hyst_en;
	} cmc_state_t;

	typedef struct packed {
		logic [7:0] in1;
		logic [7:0] in2;
		logic       sd1;
		logic       sd2;
	} cmc_sync_t;
endpackage

// File: cmc_contact_monitor.sv
// Contact monitor: modes, debounce, status, interrupt and APB registers
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`include "cmc_params.svh"
module cmc_contact_monitor import cmc_pkg::*; #(
	parameter int unsigned DEB_CYC = `CMC_DEB_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [7:0]  contact_inputs_i,
	input  wire logic        shutdown_n_pin_i,
	output logic             irq_n_o,
	output logic [1:0]       passthru_out_o,
	output logic [1:0]       passthru_oe_o,
	output logic [7:0]       sense_pullup_o,
	output logic [7:0]       sense_pulldown_o,
	output logic [7:0]       wetting_en_o,
	output logic             hyst_en_o
);
	cmc_state_t r;
	cmc_state_t next_r;
	cmc_sync_t  s;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s.in1 <= contact_inputs_i;
			s.in2 <= s.in1;
			s.sd1 <= shutdown_n_pin_i;
			s.sd2 <= s.sd1;
		end
	end

	logic [7:0] direct_mask;
	logic [7:0] mon_mask;
	logic [7:0] live;
	logic [7:0] diff;
	logic       direct_path_clear;
	logic       stable_done;
	logic       xfer;
	logic       setup;
	logic [31:0] status_word;

	always_comb begin
		direct_path_clear = ~r.cmd[`CMC_CMD_DIRECT];
		direct_mask = {6'h00, {2{direct_path_clear}}};
		mon_mask = ~direct_mask;
		// Battery sensing inverts the closed-contact level
		live = s.in2 ^ {{2{r.cmd[`CMC_CMD_PAIR_B]}}, {2{r.cmd[`CMC_CMD_PAIR_A]}}, 4'h0};
		diff = (live ^ r.state) & mon_mask;
		stable_done = (r.deb_cnt >= DEB_CYC - 1);
		xfer = psel_i & penable_i;
		setup = psel_i & ~penable_i;
		status_word = {22'h0, r.mode, r.state};
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;
		// APB slave, one wait state
		if (xfer && !r.pready) begin
			next_r.pready = 1'b1;
			next_r.prdata = 32'h0000_0000;
			unique case (paddr_i)
				`CMC_ADDR_CMD: begin
					if (pwrite_i) next_r.cmd = pwdata_i & 32'h0000_3FFF;
					else next_r.prdata = r.cmd;
				end
				`CMC_ADDR_STATUS: begin
					if (!pwrite_i) next_r.prdata = status_word;
				end
				`CMC_ADDR_SCAN: begin
					if (pwrite_i) next_r.scan_period = pwdata_i[15:0];
					else next_r.prdata = {16'h0000, r.scan_period};
				end
				default: next_r.pslverr = 1'b1;
			endcase
		end
		// Release any pending interrupt at start of a transfer
		if (setup) next_r.irq_n = 1'b1;
		unique case (r.mode)
			CMC_SHUTDOWN: begin
				next_r.pending = 8'h00;
				next_r.deb_cnt = 32'h0000_0000;
				if (s.sd2) next_r.mode = CMC_NORMAL;
			end
			CMC_NORMAL, CMC_SCAN_DEB: begin
				if (diff == 8'h00) begin
					// Reverted before debounce ended: discard
					next_r.deb_cnt = 32'h0000_0000;
					next_r.pending = 8'h00;
					if (r.mode == CMC_SCAN_DEB) next_r.mode = CMC_SCAN;
				end else if (diff != r.pending) begin
					next_r.pending = diff;
					next_r.deb_cnt = 32'h0000_0000;
				end else if (stable_done) begin
					next_r.state = r.state ^ diff;
					next_r.pending = 8'h00;
					next_r.deb_cnt = 32'h0000_0000;
					if ((diff & ~r.cmd[7:0]) != 8'h00) next_r.irq_n = 1'b0;
					if (r.mode == CMC_SCAN_DEB) next_r.mode = CMC_SCAN;
				end else begin
					next_r.deb_cnt = r.deb_cnt + 32'h0000_0001;
				end
				if (r.mode == CMC_NORMAL && r.cmd[`CMC_CMD_SCAN_EN] && diff == 8'h00) next_r.mode = CMC_SCAN;
			end
			CMC_SCAN: begin
				// Sense resistors on only during the polling window
				if (r.scan_cnt >= r.scan_period) begin
					next_r.scan_cnt = 16'h0000;
					next_r.poll_cnt = 16'(`CMC_POLL_CYC);
				end else begin
					next_r.scan_cnt = r.scan_cnt + 16'h0001;
				end
				if (r.poll_cnt != 16'h0000) begin
					next_r.poll_cnt = r.poll_cnt - 16'h0001;
					if (diff != 8'h00) begin
						next_r.mode = CMC_SCAN_DEB;
						next_r.pending = diff;
						next_r.deb_cnt = 32'h0000_0000;
						next_r.poll_cnt = 16'h0000;
					end
				end
				if (!r.cmd[`CMC_CMD_SCAN_EN]) next_r.mode = CMC_NORMAL;
			end
			default: next_r.mode = CMC_SHUTDOWN;
		endcase
		if (!s.sd2) next_r.mode = CMC_SHUTDOWN;
		// Analog control outputs, registered
		next_r.hyst_en = r.cmd[`CMC_CMD_HYST_EN] && (next_r.mode == CMC_NORMAL);
		if (next_r.mode == CMC_SHUTDOWN) begin
			next_r.pull_up = 8'h00;
			next_r.pull_dn = 8'h00;
			next_r.wet_en = 8'h00;
			next_r.pass_oe = 2'b00;
		end else begin
			logic [7:0] on;
			logic [7:0] bat;
			bat = {{2{r.cmd[`CMC_CMD_PAIR_B]}}, {2{r.cmd[`CMC_CMD_PAIR_A]}}, 4'h0};
			// Scan mode keeps resistors off outside the polling window
			on = (next_r.mode == CMC_SCAN && next_r.poll_cnt == 16'h0000) ? 8'h00 : 8'hFF;
			on = on & mon_mask;
			next_r.pull_up = on & ~bat;
			next_r.pull_dn = on & bat;
			next_r.wet_en = r.cmd[`CMC_CMD_WET_EN] ? on : 8'h00;
			next_r.pass_oe = (direct_path_clear && next_r.mode == CMC_NORMAL) ? 2'b11 : 2'b00;
		end
		next_r.pass_out = s.in2[1:0];
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
			r.cmd <= `CMC_CMD_RESET;
			r.scan_period <= `CMC_SCAN_RESET;
			r.irq_n <= 1'b1;
			r.mode <= CMC_SHUTDOWN;
		end else begin
			r <= next_r;
		end
	end

	assign prdata_o = r.prdata;
	assign pready_o = r.pready;
	assign pslverr_o = r.pslverr;
	assign irq_n_o = r.irq_n;
	assign passthru_out_o = r.pass_out;
	assign passthru_oe_o = r.pass_oe;
	assign sense_pullup_o = r.pull_up;
	assign sense_pulldown_o = r.pull_dn;
	assign wetting_en_o = r.wet_en;
	assign hyst_en_o = r.hyst_en;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_setup;
		psel_i && !penable_i;
	endsequence

	a_shutdown_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_SHUTDOWN |-> (sense_pullup_o | sense_pulldown_o | wetting_en_o) == 8'h00)
		else $error("inputs not high impedance in shutdown");
	a_sd_enter: assert property (@(posedge clk_i) disable iff (rst_i)
		!s.sd2 |=> r.mode == CMC_SHUTDOWN)
		else $error("shutdown pin low did not enter shutdown");
	// A debounced change in the same cycle as a setup phase still raises the interrupt
	a_irq_release: assert property (@(posedge clk_i) disable iff (rst_i)
		s_setup |=> irq_n_o || r.state != $past(r.state))
		else $error("interrupt not released at transfer start");
	a_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(irq_n_o) |-> $past(r.state) != r.state)
		else $error("interrupt without status change");
	a_direct_status: assert property (@(posedge clk_i) disable iff (rst_i)
		direct_path_clear && $past(direct_path_clear) |-> r.state[1:0] == $past(r.state[1:0]))
		else $error("direct input status changed");
	a_pass_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_SCAN |-> passthru_oe_o == 2'b00)
		else $error("pass-through driven in scan mode");
	a_direct_res: assert property (@(posedge clk_i) disable iff (rst_i)
		direct_path_clear && $past(direct_path_clear) |-> sense_pullup_o[1:0] == 2'b00)
		else $error("sense resistor on direct input");
	a_pull_polar: assert property (@(posedge clk_i) disable iff (rst_i)
		(sense_pullup_o & sense_pulldown_o) == 8'h00)
		else $error("pull-up and pull-down both on");

	// ----------------------------------------
	// Mode, debounce and output checks
	// ----------------------------------------
	sequence s_scan_change;
		r.mode == CMC_SCAN && r.poll_cnt != 16'h0000 && diff != 8'h00 && s.sd2 && r.cmd[`CMC_CMD_SCAN_EN];
	endsequence

	sequence s_in_scan_deb;
		r.mode == CMC_SCAN_DEB;
	endsequence

	a_pass_direct: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(direct_path_clear) |-> passthru_oe_o == 2'b00)
		else $error("pass-through driven with direct bit set");
	a_pass_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_NORMAL && $past(direct_path_clear) |-> passthru_oe_o == 2'b11)
		else $error("pass-through not driven in normal mode");
	a_pass_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		passthru_out_o == $past(s.in2[1:0]))
		else $error("pass-through does not follow inputs");
	a_irq_block: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(irq_n_o) |-> ((r.state ^ $past(r.state)) & ~$past(r.cmd[7:0])) != 8'h00)
		else $error("interrupt from blocked input");
	a_status_irq: assert property (@(posedge clk_i) disable iff (rst_i)
		((r.state ^ $past(r.state)) & ~$past(r.cmd[7:0])) != 8'h00 |-> !irq_n_o)
		else $error("enabled change did not raise interrupt");
	a_reset_cmd: assert property (@(posedge clk_i)
		$fell(rst_i) |-> r.cmd == `CMC_CMD_RESET && irq_n_o)
		else $error("command defaults wrong after reset");
	a_reset_mode: assert property (@(posedge clk_i)
		$fell(rst_i) |-> r.mode == CMC_SHUTDOWN)
		else $error("mode not shutdown after reset");
	a_run_needs_pin: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode != CMC_SHUTDOWN |-> $past(s.sd2))
		else $error("left shutdown with pin low");
	a_deb_time: assert property (@(posedge clk_i) disable iff (rst_i)
		r.state != $past(r.state) |-> $past(r.deb_cnt) >= DEB_CYC - 1)
		else $error("status updated before debounce time");
	a_scan_wake: assert property (@(posedge clk_i) disable iff (rst_i)
		s_scan_change |=> s_in_scan_deb)
		else $error("scan change did not start debounce");
	a_scan_back: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_SCAN_DEB && diff == 8'h00 && s.sd2 |=> r.mode == CMC_SCAN)
		else $error("reverted input did not return to scan");
	a_scan_done: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_SCAN_DEB && diff != 8'h00 && diff == r.pending && stable_done && s.sd2
		|=> r.mode == CMC_SCAN)
		else $error("finished debounce did not return to scan");
	a_scan_window: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_SCAN && r.poll_cnt == 16'h0000 |-> (sense_pullup_o | sense_pulldown_o | wetting_en_o) == 8'h00)
		else $error("sense resistors on outside poll window");
	a_normal_sense: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_NORMAL |-> (sense_pullup_o | sense_pulldown_o) == $past(mon_mask))
		else $error("normal mode sense resistors wrong");
	a_ground_pins: assert property (@(posedge clk_i) disable iff (rst_i)
		sense_pulldown_o[3:0] == 4'h0)
		else $error("low inputs not ground sensing");
	a_pair_a: assert property (@(posedge clk_i) disable iff (rst_i)
		sense_pulldown_o[5:4] != 2'b00 |-> $past(r.cmd[`CMC_CMD_PAIR_A]))
		else $error("first pair pulled down while ground sensing");
	a_pair_b: assert property (@(posedge clk_i) disable iff (rst_i)
		sense_pulldown_o[7:6] != 2'b00 |-> $past(r.cmd[`CMC_CMD_PAIR_B]))
		else $error("second pair pulled down while ground sensing");
	a_hyst_mode: assert property (@(posedge clk_i) disable iff (rst_i)
		hyst_en_o |-> r.mode == CMC_NORMAL && $past(r.cmd[`CMC_CMD_HYST_EN]))
		else $error("hysteresis on outside normal mode");
	a_wet_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(r.cmd[`CMC_CMD_WET_EN]) |-> wetting_en_o == 8'h00)
		else $error("wetting on while disabled");
	a_wet_common: assert property (@(posedge clk_i) disable iff (rst_i)
		wetting_en_o != 8'h00 |-> wetting_en_o == (sense_pullup_o | sense_pulldown_o))
		else $error("wetting not common to sensed inputs");
	a_shut_pass: assert property (@(posedge clk_i) disable iff (rst_i)
		r.mode == CMC_SHUTDOWN |-> passthru_oe_o == 2'b00)
		else $error("pass-through driven in shutdown");
	a_ready_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (@(posedge clk_i) disable iff (rst_i)
		pslverr_o |-> pready_o)
		else $error("error without ready");
	a_err_read: assert property (@(posedge clk_i) disable iff (rst_i)
		pslverr_o |-> prdata_o == 32'h0000_0000)
		else $error("refused access returned data");
endmodule

// File: cmc_switch_bank.sv
// Behavioural bank of remote switches and the shutdown pin
`timescale 1ns/1ns
module cmc_switch_bank (
	input  wire logic       clk_i,
	output logic      [7:0] contact_o,
	output logic            shutdown_n_o
);
	// Switches are always driven, so no released line to model
	initial begin
		contact_o = 8'h00;
		shutdown_n_o = 1'b1;
	end

	task automatic set_level(input int idx, input logic lvl);
		@(posedge clk_i);
		contact_o[idx] <= lvl;
	endtask

	// Contact bounce shorter than debounce must be discarded
	task automatic bounce(input int idx, input int cyc);
		@(posedge clk_i);
		contact_o[idx] <= ~contact_o[idx];
		repeat (cyc) @(posedge clk_i);
		contact_o[idx] <= ~contact_o[idx];
	endtask

	task automatic power(input logic on);
		@(posedge clk_i);
		shutdown_n_o <= on;
	endtask
endmodule

// File: tb_cmc_contact_monitor.sv
// Self-checking testbench for the contact monitor
`timescale 1ns/1ns
module tb_cmc_contact_monitor;
	logic        clk_i;
	logic        rst_i;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  cin;
	logic        sdn;
	logic        irq_n;
	logic [1:0]  pout;
	logic [1:0]  poe;
	logic [7:0]  pu;
	logic [7:0]  pd;
	logic [7:0]  wet;
	logic        hyst;
	logic [31:0] q;
	logic        e;
	int          n_mismatch;
	int          total_checks;

	cmc_switch_bank i_cmc_switch_bank (.clk_i(clk_i), .contact_o(cin), .shutdown_n_o(sdn));

	cmc_contact_monitor #(.DEB_CYC(8)) i_cmc_contact_monitor (
		.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.contact_inputs_i(cin), .shutdown_n_pin_i(sdn), .irq_n_o(irq_n), .passthru_out_o(pout),
		.passthru_oe_o(poe), .sense_pullup_o(pu), .sense_pulldown_o(pd), .wetting_en_o(wet),
		.hyst_en_o(hyst));

	// ----------------------------------------
	// Clock, checks and bus tasks
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic close_out();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		if (n >= 50) n_mismatch++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		n_mismatch = 0;
		total_checks = 0;
		rst_i = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		idle(2);
		rst_i <= 1'b0;
		idle(6);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk(q, 32'h0000_0100);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		chk({24'h00_0000, pu}, 32'h0000_00fc);
		chk({24'h00_0000, pd}, 32'h0000_0000);
		chk({30'h0, poe}, 32'h0000_0003);
		chk({23'h0, hyst, wet}, 32'h0000_0000);
		i_cmc_switch_bank.set_level(0, 1'b1);
		idle(20);
		chk({30'h0, pout}, 32'h0000_0001);
		chk({31'h0, irq_n}, 32'h0000_0001);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		i_cmc_switch_bank.set_level(0, 1'b0);
		i_cmc_switch_bank.bounce(3, 3);
		idle(20);
		chk({31'h0, irq_n}, 32'h0000_0001);
		i_cmc_switch_bank.set_level(2, 1'b1);
		idle(20);
		chk({31'h0, irq_n}, 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0004);
		chk({31'h0, irq_n}, 32'h0000_0001);
		apb(1'b1, 12'h000, 32'h0000_0010);
		i_cmc_switch_bank.set_level(4, 1'b1);
		idle(20);
		chk({31'h0, irq_n}, 32'h0000_0001);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q, 32'h0000_0014);
		apb(1'b1, 12'h000, 32'h0000_03ff);
		idle(2);
		chk({pu, pd}, 32'h0000_0cf0);
		apb(1'b1, 12'h000, 32'h0000_04ff);
		idle(2);
		chk({30'h0, poe}, 32'h0000_0000);
		chk({24'h00_0000, pu}, 32'h0000_00ff);
		apb(1'b1, 12'h000, 32'h0000_34ff);
		idle(2);
		chk({23'h0, hyst, wet}, 32'h0000_01ff);
		apb(1'b0, 12'h00c, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		apb(1'b1, 12'h000, 32'h0000_0800);
		idle(4);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q & 32'h0000_0300, 32'h0000_0100);
		i_cmc_switch_bank.set_level(3, 1'b1);
		idle(300);
		chk({31'h0, irq_n}, 32'h0000_0000);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q & 32'h0000_03ff, 32'h0000_011c);
		apb(1'b1, 12'h000, 32'h0000_0000);
		idle(4);
		chk({30'h0, poe}, 32'h0000_0003);
		i_cmc_switch_bank.power(1'b0);
		idle(6);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk(q & 32'h0000_0300, 32'h0000_0200);
		chk({pu, pd}, 32'h0000_0000);
		close_out();
	end

	// Whole sequence needs well under 1000 cycles
	initial begin
		#(40 * 5000);
		n_mismatch++;
		close_out();
	end
endmodule
